// File: pkg/chan_cfg.svh
// Command bytes, status codes and key constants of the parameter channel
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH
`define CMD_POS_RD    8'h42
`define CMD_POS_SET   8'h43
`define CMD_ANA_RD    8'h44
`define CMD_CNT_RD    8'h46
`define CMD_CNT_INC   8'h47
`define CMD_CNT_CLR   8'h49
`define CMD_DATA_RD   8'h4A
`define CMD_DATA_WR   8'h4B
`define CMD_FLD_STAT  8'h4C
`define CMD_FLD_NEW   8'h4D
`define CMD_MEM_FREE  8'h4E
`define CMD_KEY_CHG   8'h4F
`define CMD_STAT_RD   8'h50
`define CMD_MODEL_RD  8'h52
`define CMD_RESET     8'h53
`define CMD_ADDR_SET  8'h55
`define CMD_SER_RD    8'h56
`define CMD_IF_CFG    8'h57
`define ST_OK         8'h00
`define ST_ALIGN      8'h01
`define ST_OFFSET     8'h02
`define ST_PART       8'h03
`define ST_LIMITS     8'h04
`define ST_I2C        8'h05
`define ST_ICSUM      8'h06
`define ST_RESTART    8'h07
`define ST_CNT_OVF    8'h08
`define ST_PARITY     8'h09
`define ST_CSUM       8'h0A
`define ST_UNKNOWN    8'h0B
`define ST_LENGTH     8'h0C
`define ST_ARG        8'h0D
`define ST_WPROT      8'h0E
`define ST_ACCESS     8'h0F
`define ST_SIZE       8'h10
`define ST_WADDR      8'h11
`define ST_NOFIELD    8'h12
`define ST_ANALOG     8'h01
`define ST_SPEED      8'h1F
`define ST_STURN      8'h20
`define ST_MTURN0     8'h21
`define ST_PROC_MON   8'h1C
`define ST_CURRENT    8'h1D
`define ST_TEMP       8'h1E
`define KEY_RESET     8'h55
`endif

// File: pkg/chan_pkg.sv
// Types and the command decode function of the parameter channel
`default_nettype none
package chan_pkg;
  `include "chan_cfg.svh"

  typedef enum logic [4:0] {
    OP_NONE, OP_POS_RD, OP_POS_SET, OP_ANA_RD, OP_CNT_RD, OP_CNT_INC, OP_CNT_CLR,
    OP_DATA_RD, OP_DATA_WR, OP_FLD_STAT, OP_FLD_NEW, OP_MEM_FREE, OP_KEY_CHG,
    OP_STAT_RD, OP_MODEL_RD, OP_RESET, OP_ADDR_SET, OP_SER_RD, OP_IF_CFG
  } op_type;

  // Maps a command byte to its operation; OP_NONE marks an unknown code
  function automatic op_type op_of(input logic [7:0] code);
    case (code)
      `CMD_POS_RD:   op_of = OP_POS_RD;
      `CMD_POS_SET:  op_of = OP_POS_SET;
      `CMD_ANA_RD:   op_of = OP_ANA_RD;
      `CMD_CNT_RD:   op_of = OP_CNT_RD;
      `CMD_CNT_INC:  op_of = OP_CNT_INC;
      `CMD_CNT_CLR:  op_of = OP_CNT_CLR;
      `CMD_DATA_RD:  op_of = OP_DATA_RD;
      `CMD_DATA_WR:  op_of = OP_DATA_WR;
      `CMD_FLD_STAT: op_of = OP_FLD_STAT;
      `CMD_FLD_NEW:  op_of = OP_FLD_NEW;
      `CMD_MEM_FREE: op_of = OP_MEM_FREE;
      `CMD_KEY_CHG:  op_of = OP_KEY_CHG;
      `CMD_STAT_RD:  op_of = OP_STAT_RD;
      `CMD_MODEL_RD: op_of = OP_MODEL_RD;
      `CMD_RESET:    op_of = OP_RESET;
      `CMD_ADDR_SET: op_of = OP_ADDR_SET;
      `CMD_SER_RD:   op_of = OP_SER_RD;
      `CMD_IF_CFG:   op_of = OP_IF_CFG;
      default:       op_of = OP_NONE;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: pkg/chan_if.sv
// Internal carrier between the interpreter, its decoder and its fault encoder
`default_nettype none
interface chan_if;
  import chan_pkg::*;
  logic        cmd_valid;   // Frame arrives
  logic [7:0]  cmd_byte;    // Raw command byte
  logic        op_valid;    // Decoded op ready
  op_type      op;          // Decoded operation
  logic [5:0]  init_flt;    // Initialization faults
  logic [5:0]  pos_flt;     // Position faults
  logic [3:0]  oth_flt;     // Other faults
  logic [7:0]  flt_code;    // Encoded device fault

  modport dec_side (input cmd_valid, cmd_byte, output op_valid, op);
  modport flt_side (input init_flt, pos_flt, oth_flt, output flt_code);
  modport top_side (output cmd_valid, cmd_byte, init_flt, pos_flt, oth_flt,
                    input op_valid, op, flt_code);
endinterface
`default_nettype wire

// File: rtl/cmd_decode.sv
// Registered command byte decoder
`default_nettype none
module cmd_decode (
  input  wire logic clk_sys,      // System clock
  input  wire logic rst_n,        // Async reset, active low
  chan_if.dec_side  bus           // Command in, op out
);
  import chan_pkg::*;

  logic   op_valid_ff;
  logic   nxt_op_valid;
  op_type op_ff;
  op_type nxt_op;

  // Decode in the cycle after arrival so the interpreter sees a settled op
  always_comb
  begin
    nxt_op_valid = bus.cmd_valid;
    nxt_op       = bus.cmd_valid ? op_of(bus.cmd_byte) : OP_NONE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_valid_ff <= 1'b0;
      op_ff       <= OP_NONE;
    end
    else
    begin
      op_valid_ff <= nxt_op_valid;
      op_ff       <= nxt_op;
    end
  end

  assign bus.op_valid = op_valid_ff;
  assign bus.op       = op_ff;

  // Every arrival yields exactly one decoded op one cycle later
  dec_timing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus.cmd_valid |=> op_valid_ff && op_ff == op_of($past(bus.cmd_byte)))
    else $error("decoded op missing or wrong");
endmodule
`default_nettype wire

// File: rtl/fault_encode.sv
// Priority encoder turning device fault levels into one status code
`default_nettype none
`include "chan_cfg.svh"
module fault_encode (
  input  wire logic clk_sys,      // System clock
  input  wire logic rst_n,        // Async reset, active low
  chan_if.flt_side  bus           // Fault levels in, code out
);
  import chan_pkg::*;

  localparam int NF = 16;
  // Order sets priority: initialization, then position, then other
  localparam logic [7:0] CODES [NF] = '{
    `ST_ALIGN, `ST_OFFSET, `ST_PART, `ST_LIMITS, `ST_I2C, `ST_ICSUM,
    `ST_ANALOG, `ST_SPEED, `ST_STURN, `ST_MTURN0, `ST_MTURN0 + 8'h01,
    `ST_MTURN0 + 8'h02, `ST_PROC_MON, `ST_CURRENT, `ST_TEMP, `ST_CNT_OVF};

  logic [NF-1:0] flt;
  logic [7:0]    code_ff;
  logic [7:0]    nxt_code;

  assign flt = {bus.oth_flt, bus.pos_flt, bus.init_flt};

  // Lowest set index wins; no fault reports the all-clear code
  always_comb
  begin
    nxt_code = `ST_OK;
    for (int i = NF - 1; i >= 0; i--)
    begin
      if (flt[i])
        nxt_code = CODES[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      code_ff <= `ST_OK;
    else
      code_ff <= nxt_code;
  end

  assign bus.flt_code = code_ff;

  flt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flt == '0 |=> code_ff == `ST_OK)
    else $error("clear faults must give code 00h");
  flt_init_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus.init_flt[0] |=> code_ff == `ST_ALIGN)
    else $error("alignment fault must win with 01h");
  flt_temp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flt == 16'h4000 |=> code_ff == `ST_TEMP)
    else $error("temperature alone must give 1Eh");
endmodule
`default_nettype wire

// File: rtl/param_channel.sv
// Command interpreter and status reporting of the encoder parameter channel
`default_nettype none
`include "chan_cfg.svh"
module param_channel #(
  parameter logic [7:0] MODEL_ID = 8'hA5   // Arbitrary model identifier value
) (
  input  wire logic           clk_sys,     // System clock, 100 MHz
  input  wire logic           rst_n,       // Async reset, active low
  input  wire logic           cmd_valid,   // One-cycle frame strobe
  input  wire logic [7:0]     cmd_byte,    // Command byte of the frame
  input  wire logic [7:0]     key_byte,    // Protection key byte of the frame
  input  wire logic [7:0]     arg_byte,    // First argument byte
  input  wire logic           parity_err,  // Frame had a parity error
  input  wire logic           csum_err,    // Frame checksum wrong
  input  wire logic           len_err,     // Wrong data byte count
  input  wire logic           arg_err,     // Argument not allowed
  input  wire logic [4:0]     dmem_err,    // Data-memory error pulses
  input  wire logic           wdog_rst,    // Supervisor restart pulse
  input  wire logic [5:0]     init_flt,    // Initialization fault levels
  input  wire logic [5:0]     pos_flt,     // Position fault levels
  input  wire logic [3:0]     oth_flt,     // Other fault levels
  output logic                exec_ff,     // Execute strobe
  output chan_pkg::op_type    exec_op_ff,  // Operation to execute
  output logic [7:0]          exec_arg_ff, // Argument of executed op
  output logic                resp_ff,     // Response byte strobe
  output logic [7:0]          resp_byte_ff,// Response byte
  output logic [7:0]          status_ff,   // Current status code
  output logic [7:0]          key_ff       // Protection key in force
);
  import chan_pkg::*;

  chan_if ch ();

  // Frame qualifiers held one cycle to line up with the decoded op
  logic       par_q;
  logic       csum_q;
  logic       len_q;
  logic       arg_q;
  logic [7:0] key_q;
  logic [7:0] argb_q;

  // Latched errors and outputs
  logic [7:0] err_ff;
  logic       restart_ff;
  logic [7:0] nxt_err;
  logic       nxt_restart;
  logic       nxt_exec;
  op_type     nxt_exec_op;
  logic [7:0] nxt_exec_arg;
  logic       nxt_resp;
  logic [7:0] nxt_resp_byte;
  logic [7:0] nxt_status;
  logic [7:0] nxt_key;
  logic [7:0] frame_err;
  logic [7:0] dmem_code;
  logic [7:0] cur_status;
  logic       accept;
  logic       stat_read;

  assign ch.cmd_valid = cmd_valid;
  assign ch.cmd_byte  = cmd_byte;
  assign ch.init_flt  = init_flt;
  assign ch.pos_flt   = pos_flt;
  assign ch.oth_flt   = oth_flt;

  cmd_decode u_dec (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .bus     (ch.dec_side)
  );

  fault_encode u_flt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .bus     (ch.flt_side)
  );

  // Pipeline stage for the frame flags
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_q  <= 1'b0;
      csum_q <= 1'b0;
      len_q  <= 1'b0;
      arg_q  <= 1'b0;
      key_q  <= 8'h00;
      argb_q <= 8'h00;
    end
    else
    begin
      par_q  <= parity_err;
      csum_q <= csum_err;
      len_q  <= len_err;
      arg_q  <= arg_err;
      key_q  <= key_byte;
      argb_q <= arg_byte;
    end
  end

  // First failing check of a frame; parity is judged before anything else
  // because a corrupt byte makes every later check meaningless
  always_comb
  begin
    frame_err = `ST_OK;
    if (par_q)
      frame_err = `ST_PARITY;
    else if (csum_q)
      frame_err = `ST_CSUM;
    else if (ch.op == OP_NONE)
      frame_err = `ST_UNKNOWN;
    else if (len_q)
      frame_err = `ST_LENGTH;
    else if (arg_q)
      frame_err = `ST_ARG;
    else if ((ch.op == OP_IF_CFG || ch.op == OP_KEY_CHG) && key_q != key_ff)
      frame_err = `ST_ACCESS;
  end

  // Data-memory error pulses encoded lowest bit first
  always_comb
  begin
    dmem_code = `ST_OK;
    for (int i = 4; i >= 0; i--)
    begin
      if (dmem_err[i])
        dmem_code = `ST_WPROT + 8'(i);
    end
  end

  assign accept     = ch.op_valid && frame_err == `ST_OK;
  assign stat_read  = accept && ch.op == OP_STAT_RD;
  // Latched errors mask device faults until software reads status
  assign cur_status = (err_ff != `ST_OK) ? err_ff :
                      restart_ff ? `ST_RESTART : ch.flt_code;

  // Next state of the interpreter
  always_comb
  begin
    nxt_err       = err_ff;
    nxt_restart   = restart_ff;
    nxt_key       = key_ff;
    nxt_exec      = accept;
    nxt_exec_op   = accept ? ch.op : OP_NONE;
    nxt_exec_arg  = argb_q;
    nxt_resp      = 1'b0;
    nxt_resp_byte = resp_byte_ff;
    // A status read hands over the code and clears the latched errors
    if (stat_read)
    begin
      nxt_err     = `ST_OK;
      nxt_restart = 1'b0;
    end
    // The encoder reset also drops stale errors
    if (accept && ch.op == OP_RESET)
    begin
      nxt_err     = `ST_OK;
      nxt_restart = 1'b0;
    end
    if (accept && ch.op == OP_KEY_CHG)
      nxt_key = argb_q;
    // New events are placed last so a set beats a same-cycle clear
    if (wdog_rst)
      nxt_restart = 1'b1;
    if (dmem_code != `ST_OK)
      nxt_err = dmem_code;
    if (ch.op_valid && frame_err != `ST_OK)
      nxt_err = frame_err;
    case (accept ? ch.op : OP_NONE)
      OP_STAT_RD:
      begin
        nxt_resp      = 1'b1;
        nxt_resp_byte = cur_status;
      end
      OP_MODEL_RD:
      begin
        nxt_resp      = 1'b1;
        nxt_resp_byte = MODEL_ID;
      end
      default:
      begin
        nxt_resp = 1'b0;
      end
    endcase
    nxt_status = cur_status;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_ff       <= `ST_OK;
      restart_ff   <= 1'b0;
      key_ff       <= `KEY_RESET;
      exec_ff      <= 1'b0;
      exec_op_ff   <= OP_NONE;
      exec_arg_ff  <= 8'h00;
      resp_ff      <= 1'b0;
      resp_byte_ff <= 8'h00;
      status_ff    <= `ST_OK;
    end
    else
    begin
      err_ff       <= nxt_err;
      restart_ff   <= nxt_restart;
      key_ff       <= nxt_key;
      exec_ff      <= nxt_exec;
      exec_op_ff   <= nxt_exec_op;
      exec_arg_ff  <= nxt_exec_arg;
      resp_ff      <= nxt_resp;
      resp_byte_ff <= nxt_resp_byte;
      status_ff    <= nxt_status;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // A good frame of a known command reaches execution two cycles on
  sequence good_frame(logic [7:0] c);
    cmd_valid && cmd_byte == c && !parity_err && !csum_err && !len_err && !arg_err;
  endsequence

  sequence bad_parity;
    cmd_valid && parity_err;
  endsequence

  model_id_a: assert property (good_frame(`CMD_MODEL_RD)
    |=> ##1 resp_ff && resp_byte_ff == MODEL_ID)
    else $error("model id not returned");
  parity_latch_a: assert property (bad_parity
    |=> ##1 !exec_ff && err_ff == `ST_PARITY)
    else $error("parity error not latched or frame executed");
  unknown_cmd_a: assert property (good_frame(8'h60)
    |=> ##1 !exec_ff && err_ff == `ST_UNKNOWN)
    else $error("unknown command not flagged");
  cfg_key_a: assert property (good_frame(`CMD_IF_CFG) ##0 key_byte != key_ff
    ##1 key_ff == $past(key_ff) |=> !exec_ff && err_ff == `ST_ACCESS)
    else $error("wrong key accepted");
  restart_code_a: assert property (wdog_rst && err_ff == `ST_OK && !ch.op_valid
    && dmem_err == '0 |=> ##1 status_ff == `ST_RESTART)
    else $error("restart code missing");
  dmem_code_a: assert property (dmem_err == 5'h10 && !ch.op_valid
    |=> err_ff == `ST_NOFIELD)
    else $error("non-existent field code wrong");
  mgmt_exec_a: assert property (good_frame(`CMD_RESET)
    |=> ##1 exec_ff && exec_op_ff == OP_RESET)
    else $error("reset command not executed");
  data_exec_a: assert property (good_frame(`CMD_DATA_WR)
    |=> ##1 exec_ff && exec_op_ff == OP_DATA_WR)
    else $error("store data not executed");

  // Frame that clears parity and checksum, the first two checks
  sequence clean_link;
    cmd_valid && !parity_err && !csum_err;
  endsequence

  // Later refusals in their order; a refused frame never executes
  csum_latch_a: assert property (cmd_valid && !parity_err && csum_err
    |=> ##1 !exec_ff && err_ff == `ST_CSUM)
    else $error("checksum error not latched or frame executed");
  len_latch_a: assert property (clean_link ##0 (op_of(cmd_byte) != OP_NONE && len_err)
    |=> ##1 !exec_ff && err_ff == `ST_LENGTH)
    else $error("length error not latched or frame executed");
  arg_latch_a: assert property (clean_link ##0 (op_of(cmd_byte) != OP_NONE && !len_err
    && arg_err)
    |=> ##1 !exec_ff && err_ff == `ST_ARG)
    else $error("argument error not latched or frame executed");
  no_exec_err_a: assert property (ch.op_valid && frame_err != `ST_OK |=> !exec_ff)
    else $error("refused frame executed");

  // Key load, responses and set-beats-clear behaviour
  key_load_a: assert property (good_frame(`CMD_KEY_CHG) ##0 key_byte == key_ff
    |=> ##1 key_ff == $past(arg_byte, 2))
    else $error("matching key change did not load the new key");
  stat_resp_a: assert property (good_frame(`CMD_STAT_RD)
    |=> ##1 resp_ff && resp_byte_ff == $past(cur_status))
    else $error("status read did not return the held code");
  resp_only_a: assert property (resp_ff |-> $past(accept)
    && ($past(ch.op) == OP_STAT_RD || $past(ch.op) == OP_MODEL_RD))
    else $error("response without status or model read");
  restart_win_a: assert property (wdog_rst |=> restart_ff)
    else $error("restart event lost");
  dmem_prio_a: assert property (dmem_err == 5'h16 && !ch.op_valid
    |=> err_ff == `ST_ACCESS)
    else $error("lowest data-memory error must win");
  flt_pass_a: assert property (err_ff == `ST_OK && !restart_ff
    |=> status_ff == $past(ch.flt_code))
    else $error("device fault code not shown in status");
endmodule
`default_nettype wire

// File: bench/ctrl_model.sv
// Behavioural motor controller that sends one-cycle command frames
`default_nettype none
module ctrl_model (
  input  wire logic       clk_sys,    // System clock
  output var  logic       cmd_valid,  // Frame strobe
  output var  logic [7:0] cmd_byte,   // Command byte
  output var  logic [7:0] key_byte,   // Protection key byte
  output var  logic [7:0] arg_byte,   // Argument byte
  output var  logic       parity_err, // Parity flag
  output var  logic       csum_err,   // Checksum flag
  output var  logic       len_err,    // Length flag
  output var  logic       arg_err     // Argument flag
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet line at time zero, bytes deliberately not zero
  initial
  begin
    cmd_valid  = 1'b0;
    cmd_byte   = 8'hFF;
    key_byte   = 8'hFF;
    arg_byte   = 8'hFF;
    {arg_err, len_err, csum_err, parity_err} = 4'h0;
  end

  // Presents one frame from the next falling edge; calls may follow back to back
  task automatic frame(input logic [7:0] cmd, input logic [7:0] key,
                       input logic [7:0] arg, input logic [3:0] err);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_byte  = cmd;
    key_byte  = key;
    arg_byte  = arg;
    {arg_err, len_err, csum_err, parity_err} = err;
  endtask

  // Released bytes flip so a stale value can never pass for a fresh one
  task automatic idle();
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_byte  = ~cmd_byte;
    key_byte  = ~key_byte;
    arg_byte  = ~arg_byte;
    {arg_err, len_err, csum_err, parity_err} = 4'h0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_encoder_parameter_channel.sv
// Self-checking testbench of the parameter channel interpreter
`default_nettype none
module tb_encoder_parameter_channel;
  import chan_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] MODEL = 8'h6B; // Arbitrary model identifier

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] key;
    logic [7:0] arg;
    logic [3:0] err;  // {arg, len, csum, parity}
    op_type     op;   // OP_NONE when no execute is expected
    logic [7:0] code; // Status after the frame
  } row_type;

  logic       clk_sys, rst_n, cmd_valid, parity_err, csum_err, len_err, arg_err;
  logic [7:0] cmd_byte, key_byte, arg_byte, exec_arg_ff, resp_byte_ff, status_ff, key_ff;
  logic [4:0] dmem_err;
  logic       wdog_rst, exec_ff, resp_ff;
  logic [5:0] init_flt, pos_flt;
  logic [3:0] oth_flt;
  op_type     exec_op_ff;
  int         fails, n_tests;
  row_type    r;

  // Known command set, error priority and key refusal
  row_type rows[25] = '{
    '{8'h42, 8'h55, 8'h01, 4'h0, OP_POS_RD, 8'h00}, '{8'h43, 8'h55, 8'h02, 4'h0, OP_POS_SET, 8'h00},
    '{8'h44, 8'h55, 8'h48, 4'h0, OP_ANA_RD, 8'h00}, '{8'h46, 8'h55, 8'h03, 4'h0, OP_CNT_RD, 8'h00},
    '{8'h47, 8'h55, 8'h04, 4'h0, OP_CNT_INC, 8'h00}, '{8'h49, 8'h55, 8'h05, 4'h0, OP_CNT_CLR, 8'h00},
    '{8'h4A, 8'h55, 8'h06, 4'h0, OP_DATA_RD, 8'h00}, '{8'h4B, 8'h55, 8'h07, 4'h0, OP_DATA_WR, 8'h00},
    '{8'h4C, 8'h55, 8'h08, 4'h0, OP_FLD_STAT, 8'h00}, '{8'h4D, 8'h55, 8'h09, 4'h0, OP_FLD_NEW, 8'h00},
    '{8'h4E, 8'h55, 8'h0A, 4'h0, OP_MEM_FREE, 8'h00}, '{8'h53, 8'h55, 8'h0B, 4'h0, OP_RESET, 8'h00},
    '{8'h55, 8'h55, 8'h40, 4'h0, OP_ADDR_SET, 8'h00}, '{8'h56, 8'h55, 8'h0C, 4'h0, OP_SER_RD, 8'h00},
    '{8'h57, 8'h55, 8'hE4, 4'h0, OP_IF_CFG, 8'h00}, '{8'h50, 8'h55, 8'h00, 4'h0, OP_STAT_RD, 8'h00},
    '{8'h42, 8'h55, 8'h00, 4'h1, OP_NONE, 8'h09}, '{8'h42, 8'h55, 8'h00, 4'h3, OP_NONE, 8'h09},
    '{8'h42, 8'h55, 8'h00, 4'h6, OP_NONE, 8'h0A}, '{8'h60, 8'h55, 8'h00, 4'h0, OP_NONE, 8'h0B},
    '{8'h48, 8'h55, 8'h00, 4'h4, OP_NONE, 8'h0B}, '{8'h4A, 8'h55, 8'h00, 4'h4, OP_NONE, 8'h0C},
    '{8'h4A, 8'h55, 8'h00, 4'h8, OP_NONE, 8'h0D}, '{8'h57, 8'h00, 8'hE4, 4'h0, OP_NONE, 8'h0F},
    '{8'h4F, 8'h00, 8'h3C, 4'h0, OP_NONE, 8'h0F}};
  logic [7:0] pos_codes[6] = '{8'h01, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23};
  logic [7:0] oth_codes[4] = '{8'h1C, 8'h1D, 8'h1E, 8'h08};

  ctrl_model ctl (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .key_byte(key_byte), .arg_byte(arg_byte), .parity_err(parity_err),
    .csum_err(csum_err), .len_err(len_err), .arg_err(arg_err));

  param_channel #(.MODEL_ID(MODEL)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .key_byte(key_byte), .arg_byte(arg_byte),
    .parity_err(parity_err), .csum_err(csum_err), .len_err(len_err), .arg_err(arg_err),
    .dmem_err(dmem_err), .wdog_rst(wdog_rst), .init_flt(init_flt), .pos_flt(pos_flt),
    .oth_flt(oth_flt), .exec_ff(exec_ff), .exec_op_ff(exec_op_ff),
    .exec_arg_ff(exec_arg_ff), .resp_ff(resp_ff), .resp_byte_ff(resp_byte_ff),
    .status_ff(status_ff), .key_ff(key_ff));

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Status read returns the held code, then clears the latch
  task automatic read_status(input logic [7:0] exp);
    ctl.frame(8'h50, 8'h55, 8'h00, 4'h0);
    ctl.idle();
    @(negedge clk_sys);
    chk({7'h0, resp_ff}, 8'h01);
    chk(resp_byte_ff, exp);
    repeat (2) @(negedge clk_sys);
  endtask

  // Fault levels show two edges later; wait three falling edges
  task automatic fault(input logic [5:0] i, input logic [5:0] p, input logic [3:0] o,
                       input logic [7:0] exp);
    @(negedge clk_sys);
    init_flt = i;
    pos_flt  = p;
    oth_flt  = o;
    repeat (3) @(negedge clk_sys);
    chk(status_ff, exp);
  endtask

  // Run is a few hundred cycles; this span only catches a hang
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    dmem_err = 5'h00;
    wdog_rst = 1'b0;
    {init_flt, pos_flt, oth_flt} = 16'h0000;
    fails = 0;
    n_tests = 0;
    repeat (16) @(negedge clk_sys);
    chk(key_ff, 8'h55);
    chk(status_ff, 8'h00);
    chk({2'h0, exec_ff, resp_ff, 4'h0}, 8'h00);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      ctl.frame(r.cmd, r.key, r.arg, r.err);
      ctl.idle();
      @(negedge clk_sys);
      chk({7'h0, exec_ff}, {7'h0, r.op != OP_NONE});
      if (r.op != OP_NONE)
      begin
        chk({3'h0, exec_op_ff}, {3'h0, r.op});
        chk(exec_arg_ff, r.arg);
      end
      @(negedge clk_sys);
      chk(status_ff, r.code);
      read_status(r.code);
    end
    // Each device fault alone, then priority between groups
    for (int i = 0; i < 6; i++)
      fault(6'h01 << i, 6'h00, 4'h0, 8'h01 + 8'(i));
    for (int i = 0; i < 6; i++)
      fault(6'h00, 6'h01 << i, 4'h0, pos_codes[i]);
    for (int i = 0; i < 4; i++)
      fault(6'h00, 6'h00, 4'h1 << i, oth_codes[i]);
    fault(6'h04, 6'h02, 4'h1, 8'h03);
    fault(6'h00, 6'h30, 4'h3, 8'h22);
    // Latched protocol error hides a standing fault until read
    fault(6'h01, 6'h00, 4'h0, 8'h01);
    ctl.frame(8'h42, 8'h55, 8'h00, 4'h1);
    ctl.idle();
    repeat (3) @(negedge clk_sys);
    chk(status_ff, 8'h09);
    read_status(8'h09);
    fault(6'h00, 6'h00, 4'h0, 8'h00);
    // Data-memory errors, lowest bit first
    for (int i = 0; i < 6; i++)
    begin
      dmem_err = (i < 5) ? 5'h01 << i : 5'h16;
      @(negedge clk_sys);
      dmem_err = 5'h00;
      repeat (3) @(negedge clk_sys);
      chk(status_ff, (i < 5) ? 8'h0E + 8'(i) : 8'h0F);
      read_status((i < 5) ? 8'h0E + 8'(i) : 8'h0F);
    end
    // Supervisor restart, cleared by the reset command
    wdog_rst = 1'b1;
    @(negedge clk_sys);
    wdog_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(status_ff, 8'h07);
    ctl.frame(8'h53, 8'h55, 8'h00, 4'h0);
    ctl.idle();
    repeat (4) @(negedge clk_sys);
    chk(status_ff, 8'h00);
    // Back-to-back frames
    ctl.frame(8'h42, 8'h55, 8'h11, 4'h0);
    ctl.frame(8'h4A, 8'h55, 8'h7E, 4'h0);
    ctl.idle();
    chk({3'h0, exec_op_ff}, {3'h0, OP_POS_RD});
    @(negedge clk_sys);
    chk({3'h0, exec_op_ff}, {3'h0, OP_DATA_RD});
    chk(exec_arg_ff, 8'h7E);
    // Model identifier
    ctl.frame(8'h52, 8'h55, 8'h00, 4'h0);
    ctl.idle();
    @(negedge clk_sys);
    chk({7'h0, resp_ff}, 8'h01);
    chk(resp_byte_ff, MODEL);
    // Key change, old key then refused, new key accepted
    ctl.frame(8'h4F, 8'h55, 8'h3C, 4'h0);
    ctl.idle();
    repeat (4) @(negedge clk_sys);
    chk(key_ff, 8'h3C);
    ctl.frame(8'h57, 8'h55, 8'hE4, 4'h0);
    ctl.idle();
    repeat (3) @(negedge clk_sys);
    chk(status_ff, 8'h0F);
    read_status(8'h0F);
    ctl.frame(8'h57, 8'h3C, 8'hE4, 4'h0);
    ctl.idle();
    @(negedge clk_sys);
    chk({3'h0, exec_op_ff}, {3'h0, OP_IF_CFG});
    // Reset in mid-run restores the delivered key
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(key_ff, 8'h55);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(status_ff, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
